//--- rtl/gpa_consts.svh
/*
 Offsets, field positions, reset values and timing figures of the GPIO port.
 Assumes the includer compiles it once per unit; guarded against double inclusion.
*/
`ifndef GPA_CONSTS_SVH
`define GPA_CONSTS_SVH

`define GPA_NUM_PADS      18
`define GPA_ADDR_W        8
`define GPA_TX_CNT_W      25
`define GPA_IRQ_W         5

// Register byte offsets
`define GPA_PIN_CFG_ADDR  8'h00
`define GPA_MODE_LO_ADDR  8'h04
`define GPA_MODE_HI_ADDR  8'h08
`define GPA_PAD_STATE_ADDR 8'h0C
`define GPA_RINGER_ADDR   8'h10
`define GPA_TEMPMON_ADDR  8'h14
`define GPA_ALARM_ADDR    8'h18
`define GPA_IRQ_STAT_ADDR 8'h1C
`define GPA_IRQ_CLR_ADDR  8'h20
`define GPA_IRQ_EN_ADDR   8'h24

// Pin configure command fields
`define GPA_CFG_PAD_MSB   4
`define GPA_CFG_PAD_LSB   0
`define GPA_CFG_MODE_MSB  9
`define GPA_CFG_MODE_LSB  8
`define GPA_CFG_LVL_BIT   16

// Temperature monitor fields
`define GPA_TM_EN_BIT     0
`define GPA_TM_PAD_MSB    12
`define GPA_TM_PAD_LSB    8
`define GPA_TM_MAX_MSB    23
`define GPA_TM_MAX_LSB    16

`define GPA_ALARM_CLR_BIT 0
`define GPA_RINGER_MSB    1
`define GPA_RINGER_BUZZER 2'h3

// Pad indices, zero based
`define GPA_IDX_JAM       1
`define GPA_IDX_INHIBIT   3
`define GPA_IDX_TXMON     4
`define GPA_IDX_ALARM     5
`define GPA_IDX_BUZZER    6
`define GPA_ALT_MASK      18'h0007A
`define GPA_TEMP_MASK     18'h3F3D3
`define GPA_PAD_OUT_RST   18'h00020
`define GPA_PAD_OE_RST    18'h00020

// Interrupt status bits
`define GPA_EV_ALARM      0
`define GPA_EV_TEMP       1
`define GPA_EV_TXMON      2
`define GPA_EV_INHIBIT    3
`define GPA_EV_CFG_ERR    4

// Timing
`define GPA_CLK_HZ        40000000
`define GPA_HZ_PER_KHZ    1000
`define GPA_LEAD_MS       300
`define GPA_TRAIL_MS      500

`endif

//--- rtl/gpa_gpio.sv
/*
 GPIO port with alternate functions: APB register slave, pad drivers,
 transmitter inhibit, transmit activity monitor, alarm, buzzer and
 temperature flag, with a sticky interrupt status.
 Assumes internal inputs (TX_REQ, ALARM_FIRE, BUZZER_TONE, JAM_DETECT,
 TEMP_VALUE) come from logic on REF_CLK; pads come from outside.
*/
// Added by the designer: register access over APB and the register addresses.
// What this block does
// - Input pads read sampled level, output pads read driven level, alt is internal except pad 4, which reads its sampled level
// - Pads 1, 3, 8-18 refuse alternate mode; 2, 4, 5, 6, 7 allow it
// - Input mode pad reports the level an external driver presents
// - Output mode pad drives both high and low
// - Pad 4 in alternate mode held low keeps transmitter disabled
// - Pad 5 alternate is high while transmit activity lasts
// - Monitor rises 300 ms before first burst, falls 500 ms-1 s after last
// - Alarm pad rises on alarm and stays high until alarm clear command
// - Alarm pad is high while the device is in reset
// - Pad 7 alternate forces output direction driven by internal logic
// - Level given with alternate mode is a dummy and is ignored
// - Enabled temperature flag drives its pad high at the maximum temperature
// - Temperature flag pads are 1, 8-10, 13-18, or 2, 5, 7 overriding alt
`timescale 1ns/100ps
`include "gpa_consts.svh"
module gpa_gpio #(
   parameter int unsigned LEAD_CYC  = `GPA_LEAD_MS * (`GPA_CLK_HZ / `GPA_HZ_PER_KHZ),
   parameter int unsigned TRAIL_CYC = `GPA_TRAIL_MS * (`GPA_CLK_HZ / `GPA_HZ_PER_KHZ)
) (
   input  wire logic                      REF_CLK,
   input  wire logic                      RST,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [`GPA_ADDR_W-1:0]    PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   input  wire logic [`GPA_NUM_PADS-1:0]  PAD_IN,
   output logic      [`GPA_NUM_PADS-1:0]  PAD_OUT,
   output logic      [`GPA_NUM_PADS-1:0]  PAD_OE,
   input  wire logic                      TX_REQ,
   input  wire logic                      ALARM_FIRE,
   input  wire logic                      BUZZER_TONE,
   input  wire logic                      JAM_DETECT,
   input  wire logic [7:0]                TEMP_VALUE,
   output logic                           TX_GRANT,
   output logic                           IRQ
);
   localparam logic [`GPA_TX_CNT_W-1:0] LEAD_LAST  = `GPA_TX_CNT_W'(LEAD_CYC - 1);
   localparam logic [`GPA_TX_CNT_W-1:0] TRAIL_LAST = `GPA_TX_CNT_W'(TRAIL_CYC - 1);

   gpa_pkg::gpa_pad_t        cfg_r [`GPA_NUM_PADS];
   gpa_pkg::gpa_temp_cfg_t   temp_cfg_r;
   gpa_pkg::gpa_tx_state_t   tx_state_r;
   logic [`GPA_TX_CNT_W-1:0] tx_cnt_r;
   logic [`GPA_NUM_PADS-1:0] pad_sync;
   logic [`GPA_NUM_PADS-1:0] pad_out_r;
   logic [`GPA_NUM_PADS-1:0] pad_oe_r;
   logic [`GPA_NUM_PADS-1:0] pad_out_nxt;
   logic [`GPA_NUM_PADS-1:0] pad_oe_nxt;
   logic [`GPA_NUM_PADS-1:0] alt_val;
   logic [`GPA_NUM_PADS-1:0] temp_bind;
   logic [`GPA_NUM_PADS-1:0] pad_state;
   logic [2*`GPA_NUM_PADS-1:0] mode_vec;
   logic [`GPA_IRQ_W-1:0]    irq_stat_r;
   logic [`GPA_IRQ_W-1:0]    irq_stat_nxt;
   logic [`GPA_IRQ_W-1:0]    irq_en_r;
   logic [`GPA_IRQ_W-1:0]    irq_clr;
   logic [`GPA_IRQ_W-1:0]    irq_ev;
   logic [1:0]               ringer_r;
   logic [31:0]              prdata_r;
   logic [31:0]              rdata_nxt;
   logic                     pready_r;
   logic                     pslverr_r;
   logic                     addr_hit;
   logic                     irq_r;
   logic                     tx_grant_r;
   logic                     tx_mon_r;
   logic                     alarm_r;
   logic                     temp_over_r;
   logic                     temp_over_nxt;
   logic                     inhibit;
   logic                     inhibit_r;
   logic                     acc;
   logic                     wr_en;
   logic                     cfg_wr;
   logic                     cfg_ok;
   logic                     alarm_clr;
   logic [4:0]               w_pad;
   logic [4:0]               w_idx;
   logic [1:0]               w_mode;

   assign PRDATA   = prdata_r;
   assign PREADY   = pready_r;
   assign PSLVERR  = pslverr_r;
   assign PAD_OUT  = pad_out_r;
   assign PAD_OE   = pad_oe_r;
   assign TX_GRANT = tx_grant_r;
   assign IRQ      = irq_r;

   // Pads are asynchronous to REF_CLK
   gpa_sync u_sync (
      .clk (REF_CLK),
      .rst (RST),
      .d   (PAD_IN),
      .q   (pad_sync)
   );

   // APB: one wait state so that read data comes from a flop
   assign acc   = PSEL && PENABLE;
   assign wr_en = acc && pready_r && PWRITE;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= acc && !pready_r;
      end
   end

   // Pin configure command decode
   assign cfg_wr    = wr_en && (PADDR == `GPA_PIN_CFG_ADDR);
   assign w_pad     = PWDATA[`GPA_CFG_PAD_MSB:`GPA_CFG_PAD_LSB];
   assign w_mode    = PWDATA[`GPA_CFG_MODE_MSB:`GPA_CFG_MODE_LSB];
   assign w_idx     = 5'(w_pad - 5'h01);
   assign alarm_clr = wr_en && (PADDR == `GPA_ALARM_ADDR) && PWDATA[`GPA_ALARM_CLR_BIT];

   always_comb begin
      cfg_ok = 1'b0;
      if ((w_pad != 5'h00) && (w_pad <= 5'(`GPA_NUM_PADS))) begin
         case (w_mode)
            gpa_pkg::GPA_MODE_IN:  cfg_ok = 1'b1;
            gpa_pkg::GPA_MODE_OUT: cfg_ok = 1'b1;
            gpa_pkg::GPA_MODE_ALT: cfg_ok = 1'(`GPA_ALT_MASK >> w_idx);
            default:               cfg_ok = 1'b0;
         endcase
      end
   end

   genvar i;
   generate
      for (i = 0; i < `GPA_NUM_PADS; i++) begin : g_pad
         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               cfg_r[i].mode  <= gpa_pkg::GPA_MODE_IN;
               cfg_r[i].level <= 1'b0;
            end else if (cfg_wr && cfg_ok && (w_idx == 5'(i))) begin
               cfg_r[i].mode <= gpa_pkg::gpa_mode_t'(w_mode);
               // Level only matters for outputs; dummy otherwise
               if (w_mode == gpa_pkg::GPA_MODE_OUT) begin
                  cfg_r[i].level <= PWDATA[`GPA_CFG_LVL_BIT];
               end
            end
         end

         assign temp_bind[i] = temp_cfg_r.en && 1'(`GPA_TEMP_MASK >> i)
                               && (temp_cfg_r.pad == 5'(i + 1));
         // Temperature binding overrides the pad's own alternate function
         assign pad_oe_nxt[i] = temp_bind[i]
                                || (cfg_r[i].mode == gpa_pkg::GPA_MODE_OUT)
                                || ((cfg_r[i].mode == gpa_pkg::GPA_MODE_ALT)
                                    && (i != `GPA_IDX_INHIBIT));
         assign pad_out_nxt[i] = temp_bind[i] ? temp_over_r :
                                 (cfg_r[i].mode == gpa_pkg::GPA_MODE_ALT) ? alt_val[i] :
                                 cfg_r[i].level;
         assign pad_state[i] = pad_oe_r[i] ? pad_out_r[i] : pad_sync[i];
         assign mode_vec[2*i+1:2*i] = cfg_r[i].mode;
      end
   endgenerate

   always_comb begin
      alt_val                   = '0;
      alt_val[`GPA_IDX_JAM]     = JAM_DETECT;
      alt_val[`GPA_IDX_TXMON]   = tx_mon_r;
      alt_val[`GPA_IDX_ALARM]   = alarm_r;
      // Tone reaches the pad only with the buzzer ringer path selected
      alt_val[`GPA_IDX_BUZZER]  = BUZZER_TONE && (ringer_r == `GPA_RINGER_BUZZER);
   end

   // Reset drives the alarm pad high; once out of reset it is an input until pad 6 is configured
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pad_out_r <= `GPA_PAD_OUT_RST;
         pad_oe_r  <= `GPA_PAD_OE_RST;
      end else begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
      end
   end

   // Transmitter inhibit, only in alternate mode on pad 4
   assign inhibit = (cfg_r[`GPA_IDX_INHIBIT].mode == gpa_pkg::GPA_MODE_ALT)
                    && !pad_sync[`GPA_IDX_INHIBIT];

   // Transmit activity monitor: lead before grant, trail after last request
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tx_state_r <= gpa_pkg::GPA_TX_IDLE;
         tx_cnt_r   <= '0;
      end else begin
         case (tx_state_r)
            gpa_pkg::GPA_TX_IDLE: begin
               tx_cnt_r <= '0;
               if (TX_REQ) begin
                  tx_state_r <= gpa_pkg::GPA_TX_LEAD;
               end
            end
            gpa_pkg::GPA_TX_LEAD: begin
               if (tx_cnt_r == LEAD_LAST) begin
                  tx_cnt_r   <= '0;
                  tx_state_r <= gpa_pkg::GPA_TX_ACTIVE;
               end else begin
                  tx_cnt_r <= tx_cnt_r + 1'b1;
               end
            end
            gpa_pkg::GPA_TX_ACTIVE: begin
               tx_cnt_r <= '0;
               if (!TX_REQ) begin
                  tx_state_r <= gpa_pkg::GPA_TX_TRAIL;
               end
            end
            gpa_pkg::GPA_TX_TRAIL: begin
               if (TX_REQ) begin
                  tx_cnt_r   <= '0;
                  tx_state_r <= gpa_pkg::GPA_TX_ACTIVE;
               end else if (tx_cnt_r == TRAIL_LAST) begin
                  tx_cnt_r   <= '0;
                  tx_state_r <= gpa_pkg::GPA_TX_IDLE;
               end else begin
                  tx_cnt_r <= tx_cnt_r + 1'b1;
               end
            end
            default: begin
               tx_cnt_r   <= '0;
               tx_state_r <= gpa_pkg::GPA_TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tx_mon_r   <= 1'b0;
         tx_grant_r <= 1'b0;
      end else begin
         tx_mon_r   <= (tx_state_r != gpa_pkg::GPA_TX_IDLE) || TX_REQ;
         tx_grant_r <= (tx_state_r == gpa_pkg::GPA_TX_ACTIVE) && TX_REQ && !inhibit;
      end
   end

   // Alarm: fire wins over a clear in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         alarm_r <= 1'b0;
      end else if (ALARM_FIRE) begin
         alarm_r <= 1'b1;
      end else if (alarm_clr) begin
         alarm_r <= 1'b0;
      end
   end

   // Temperature monitor
   assign temp_over_nxt = temp_cfg_r.en && (TEMP_VALUE >= temp_cfg_r.max);

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         temp_cfg_r  <= '0;
         temp_over_r <= 1'b0;
         ringer_r    <= '0;
      end else begin
         temp_over_r <= temp_over_nxt;
         if (wr_en && (PADDR == `GPA_TEMPMON_ADDR)) begin
            temp_cfg_r.en  <= PWDATA[`GPA_TM_EN_BIT];
            temp_cfg_r.pad <= PWDATA[`GPA_TM_PAD_MSB:`GPA_TM_PAD_LSB];
            temp_cfg_r.max <= PWDATA[`GPA_TM_MAX_MSB:`GPA_TM_MAX_LSB];
         end
         if (wr_en && (PADDR == `GPA_RINGER_ADDR)) begin
            ringer_r <= PWDATA[`GPA_RINGER_MSB:0];
         end
      end
   end

   // Interrupts: sticky status, set beats clear
   always_comb begin
      irq_ev                   = '0;
      irq_ev[`GPA_EV_ALARM]    = ALARM_FIRE;
      irq_ev[`GPA_EV_TEMP]     = temp_over_nxt && !temp_over_r;
      irq_ev[`GPA_EV_TXMON]    = (tx_state_r == gpa_pkg::GPA_TX_IDLE) && TX_REQ;
      irq_ev[`GPA_EV_INHIBIT]  = inhibit && !inhibit_r;
      irq_ev[`GPA_EV_CFG_ERR]  = cfg_wr && !cfg_ok;
      irq_clr = (wr_en && (PADDR == `GPA_IRQ_CLR_ADDR)) ? PWDATA[`GPA_IRQ_W-1:0] : '0;
      irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_stat_r <= '0;
         irq_en_r   <= '0;
         irq_r      <= 1'b0;
         inhibit_r  <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         inhibit_r  <= inhibit;
         if (wr_en && (PADDR == `GPA_IRQ_EN_ADDR)) begin
            irq_en_r <= PWDATA[`GPA_IRQ_W-1:0];
         end
         irq_r <= |(irq_stat_nxt & irq_en_r);
      end
   end

   // Read mux and address decode
   always_comb begin
      rdata_nxt = '0;
      addr_hit  = 1'b1;
      case (PADDR)
         `GPA_PIN_CFG_ADDR:   rdata_nxt = '0;
         `GPA_MODE_LO_ADDR:   rdata_nxt = mode_vec[31:0];
         `GPA_MODE_HI_ADDR:   rdata_nxt = 32'(mode_vec[2*`GPA_NUM_PADS-1:32]);
         `GPA_PAD_STATE_ADDR: rdata_nxt = 32'(pad_state);
         `GPA_RINGER_ADDR:    rdata_nxt = 32'(ringer_r);
         `GPA_TEMPMON_ADDR:   rdata_nxt = {8'h00, temp_cfg_r.max, 3'h0, temp_cfg_r.pad,
                                           7'h00, temp_cfg_r.en};
         `GPA_ALARM_ADDR:     rdata_nxt = {29'h0, tx_grant_r, tx_mon_r, alarm_r};
         `GPA_IRQ_STAT_ADDR:  rdata_nxt = 32'(irq_stat_r);
         `GPA_IRQ_CLR_ADDR:   rdata_nxt = '0;
         `GPA_IRQ_EN_ADDR:    rdata_nxt = 32'(irq_en_r);
         default:             addr_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else if (acc && !pready_r) begin
         prdata_r  <= PWRITE ? 32'h0 : rdata_nxt;
         pslverr_r <= !addr_hit;
      end else begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end
   end

   a_alarm_rst_high: assert property (
      @(posedge REF_CLK) RST |=> (PAD_OUT[`GPA_IDX_ALARM] && PAD_OE[`GPA_IDX_ALARM]))
      else $error("alarm pad not high in reset");
   a_mode_rst_in: assert property (
      @(posedge REF_CLK) RST |=> (cfg_r[0].mode == gpa_pkg::GPA_MODE_IN))
      else $error("pad mode not input after reset");
   a_no_alt_pad1: assert property (
      @(posedge REF_CLK) disable iff (RST) cfg_r[0].mode != gpa_pkg::GPA_MODE_ALT)
      else $error("alternate mode on pad without one");
   a_input_released: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (cfg_r[0].mode == gpa_pkg::GPA_MODE_IN) && !temp_bind[0] |=> !PAD_OE[0])
      else $error("input pad driven");
   a_push_pull_out: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (cfg_r[0].mode == gpa_pkg::GPA_MODE_OUT) && !temp_bind[0]
      |=> PAD_OE[0] && (PAD_OUT[0] == $past(cfg_r[0].level)))
      else $error("output pad not driving level");
   a_inhibit_blocks: assert property (
      @(posedge REF_CLK) disable iff (RST) inhibit |=> !TX_GRANT)
      else $error("grant while inhibited");
   a_mon_covers: assert property (
      @(posedge REF_CLK) disable iff (RST) TX_GRANT |-> tx_mon_r)
      else $error("grant without monitor high");
   a_lead_nogrant: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (tx_state_r == gpa_pkg::GPA_TX_LEAD) |=> !TX_GRANT)
      else $error("grant during lead time");
   a_trail_hold: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (tx_state_r == gpa_pkg::GPA_TX_ACTIVE) && !TX_REQ |=> tx_mon_r [*8])
      else $error("monitor fell early after activity");
   a_alarm_sticky: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (ALARM_FIRE || (alarm_r && !alarm_clr)) |=> alarm_r)
      else $error("alarm dropped without clear");
   a_buzzer_dir: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (cfg_r[`GPA_IDX_BUZZER].mode == gpa_pkg::GPA_MODE_ALT) |=> PAD_OE[`GPA_IDX_BUZZER])
      else $error("buzzer pad not output");
   a_dummy_level: assert property (
      @(posedge REF_CLK) disable iff (RST)
      cfg_wr && cfg_ok && (w_mode == gpa_pkg::GPA_MODE_ALT) && (w_idx == 5'h06)
      |=> $stable(cfg_r[`GPA_IDX_BUZZER].level))
      else $error("dummy level stored");
   a_temp_drive: assert property (
      @(posedge REF_CLK) disable iff (RST)
      temp_bind[7] && temp_over_r |=> PAD_OE[7] && PAD_OUT[7])
      else $error("temperature flag not driven");
   a_temp_override: assert property (
      @(posedge REF_CLK) disable iff (RST)
      temp_bind[`GPA_IDX_TXMON] |=> (PAD_OUT[`GPA_IDX_TXMON] == $past(temp_over_r)))
      else $error("alternate function not overridden");
endmodule

//--- rtl/gpa_pkg.sv
/*
 Types shared by the GPIO port: pad modes, per-pad configuration, transmit
 monitor states and temperature monitor setup. Assumes gpa_consts.svh alongside.
*/
package gpa_pkg;

   typedef enum logic [1:0] {
      GPA_MODE_IN  = 2'b00,
      GPA_MODE_OUT = 2'b01,
      GPA_MODE_ALT = 2'b10
   } gpa_mode_t;

   typedef struct packed {
      gpa_mode_t mode;
      logic      level;
   } gpa_pad_t;

   typedef enum logic [1:0] {
      GPA_TX_IDLE   = 2'b00,
      GPA_TX_LEAD   = 2'b01,
      GPA_TX_ACTIVE = 2'b10,
      GPA_TX_TRAIL  = 2'b11
   } gpa_tx_state_t;

   typedef struct packed {
      logic       en;
      logic [4:0] pad;
      logic [7:0] max;
   } gpa_temp_cfg_t;

endpackage

//--- rtl/gpa_sync.sv
/*
 Two-flop synchroniser for the pad inputs.
 Assumes d comes from outside the REF_CLK domain; only q may be read.
*/
`timescale 1ns/100ps
`include "gpa_consts.svh"
module gpa_sync (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [`GPA_NUM_PADS-1:0]  d,
   output logic      [`GPA_NUM_PADS-1:0]  q
);
   logic [`GPA_NUM_PADS-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

//--- verif/gpa_host_model.sv
/*
 Host side of the pads: external logic driving input pads, board pulls.
 Assumes dev_oe high means the device owns the pad that cycle.
*/
`timescale 1ns/100ps
`include "gpa_consts.svh"
module gpa_host_model (
   input  wire logic                      clk,
   input  wire logic [`GPA_NUM_PADS-1:0]  dev_out,
   input  wire logic [`GPA_NUM_PADS-1:0]  dev_oe,
   input  wire logic [`GPA_NUM_PADS-1:0]  host_lvl,
   input  wire logic [`GPA_NUM_PADS-1:0]  host_en,
   output logic      [`GPA_NUM_PADS-1:0]  pad
);
   // Pads 3, 4, 11 and 12 carry board pull-ups
   localparam logic [`GPA_NUM_PADS-1:0] PULL_UP = 18'h00C0C;
   // Defined start, else a floating pad would stay unknown forever
   logic [`GPA_NUM_PADS-1:0] last_r = '0;

   always @(posedge clk) begin
      last_r <= pad;
   end

   // Floating pads toggle, so a stale level never reads as data
   always_comb begin
      for (int i = 0; i < `GPA_NUM_PADS; i++) begin
         if (dev_oe[i])
            pad[i] = dev_out[i];
         else if (host_en[i])
            pad[i] = host_lvl[i];
         else if (PULL_UP[i])
            pad[i] = 1'b1;
         else
            pad[i] = ~last_r[i];
      end
   end
endmodule

//--- verif/tb.sv
/*
 Self-checking bench for the GPIO port: APB master tasks and scenarios.
 Assumes gpa_consts.svh and gpa_pkg are compiled alongside the design.
*/
`timescale 1ns/100ps
`include "gpa_consts.svh"
module tb;
   localparam int LEAD  = 20;
   localparam int TRAIL = 30;
   localparam int BAD[3] = '{3, 8, 18};
   logic        clk, rst, psel, penable, pwrite, tx_req, fire, tone, jam;
   logic        pready, pslverr, tx_grant, irq, err;
   logic [7:0]  paddr, temp;
   logic [31:0] pwdata, prdata, rd;
   logic [17:0] pad_in, pad_out, pad_oe, host_lvl, host_en;
   int          mismatches, compares, cyc;

   gpa_gpio #(.LEAD_CYC(LEAD), .TRAIL_CYC(TRAIL)) dut_u (
      .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
      .TX_REQ(tx_req), .ALARM_FIRE(fire), .BUZZER_TONE(tone), .JAM_DETECT(jam),
      .TEMP_VALUE(temp), .TX_GRANT(tx_grant), .IRQ(irq));

   gpa_host_model host_u (.clk(clk), .dev_out(pad_out), .dev_oe(pad_oe),
      .host_lvl(host_lvl), .host_en(host_en), .pad(pad_in));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic cfg(input int p, input int m, input int l);
      apb(1'b1, `GPA_PIN_CFG_ADDR,
          32'((l << `GPA_CFG_LVL_BIT) | (m << `GPA_CFG_MODE_LSB) | p));
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic conclude;
      if (mismatches == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         conclude;
      end
   end

   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; tx_req = 1'b0; fire = 1'b0; tone = 1'b0; jam = 1'b0;
      temp = 8'h00; host_lvl = 18'h00000; host_en = 18'h00000; cyc = 0;
      tick(20);
      chk("oe_in_reset", pad_oe, 18'h00020);
      chk("out_in_reset", pad_out, 18'h00020);
      rst <= 1'b0;
      tick(2);
      chk("oe_after_reset", pad_oe, 18'h00000);
      apb(1'b0, `GPA_MODE_LO_ADDR, 32'h0);
      chk("mode_reset", rd, 32'h0);
      cfg(1, gpa_pkg::GPA_MODE_OUT, 1);
      tick(3);
      chk("pad1_oe", pad_oe[0], 1'b1);
      chk("pad1_high", pad_out[0], 1'b1);
      apb(1'b0, `GPA_PAD_STATE_ADDR, 32'h0);
      chk("pad1_state", rd[0], 1'b1);
      cfg(1, gpa_pkg::GPA_MODE_OUT, 0);
      tick(3);
      chk("pad1_low", {pad_oe[0], pad_out[0]}, 2'b10);
      host_en[2] <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         host_lvl[2] <= v[0];
         cfg(3, gpa_pkg::GPA_MODE_IN, 1);
         tick(5);
         apb(1'b0, `GPA_PAD_STATE_ADDR, 32'h0);
         chk("pad3_input", {pad_oe[2], rd[2]}, {1'b0, v[0]});
      end
      // Refused alternate modes, first masked then enabled
      cfg(1, gpa_pkg::GPA_MODE_ALT, 0);
      tick(2);
      chk("irq_masked", irq, 1'b0);
      apb(1'b1, `GPA_IRQ_EN_ADDR, 32'h10);
      tick(2);
      chk("irq_raised", irq, 1'b1);
      chk("pad1_kept", pad_oe[0], 1'b1);
      foreach (BAD[i]) begin
         apb(1'b1, `GPA_IRQ_CLR_ADDR, 32'h10);
         cfg(BAD[i], gpa_pkg::GPA_MODE_ALT, 0);
         apb(1'b0, `GPA_IRQ_STAT_ADDR, 32'h0);
         chk("cfg_refused", rd[4], 1'b1);
      end
      apb(1'b1, `GPA_IRQ_CLR_ADDR, 32'h10);
      tick(2);
      chk("irq_cleared", irq, 1'b0);
      apb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      // Alarm: raise, hold, clear
      cfg(6, gpa_pkg::GPA_MODE_ALT, 0);
      tick(3);
      chk("alarm_idle", {pad_oe[5], pad_out[5]}, 2'b10);
      fire <= 1'b1;
      tick(1);
      fire <= 1'b0;
      tick(12);
      chk("alarm_held", pad_out[5], 1'b1);
      apb(1'b1, `GPA_ALARM_ADDR, 32'h1);
      tick(3);
      chk("alarm_cleared", pad_out[5], 1'b0);
      // Buzzer with dummy level 1, jamming output on pad 2
      cfg(7, gpa_pkg::GPA_MODE_ALT, 1);
      apb(1'b1, `GPA_RINGER_ADDR, 32'h3);
      cfg(2, gpa_pkg::GPA_MODE_ALT, 0);
      for (int v = 0; v < 2; v++) begin
         tone <= v[0];
         jam <= v[0];
         tick(3);
         chk("buzzer", {pad_oe[6], pad_out[6]}, {1'b1, v[0]});
         chk("jam_pad", pad_out[1], v[0]);
      end
      // Transmit monitor and inhibit
      host_en[3] <= 1'b1;
      host_lvl[3] <= 1'b1;
      cfg(5, gpa_pkg::GPA_MODE_ALT, 0);
      cfg(4, gpa_pkg::GPA_MODE_ALT, 0);
      tx_req <= 1'b1;
      tick(5);
      chk("mon_lead", {pad_out[4], tx_grant}, 2'b10);
      tick(LEAD);
      chk("grant", tx_grant, 1'b1);
      host_lvl[3] <= 1'b0;
      tick(8);
      chk("inhibited", tx_grant, 1'b0);
      host_lvl[3] <= 1'b1;
      tick(8);
      chk("released", tx_grant, 1'b1);
      tx_req <= 1'b0;
      tick(5);
      chk("mon_trail", {pad_out[4], tx_grant}, 2'b10);
      tick(TRAIL - 10);
      chk("mon_held", pad_out[4], 1'b1);
      tick(10);
      chk("mon_low", pad_out[4], 1'b0);
      apb(1'b0, `GPA_IRQ_STAT_ADDR, 32'h0);
      chk("alt_accepted", rd[4], 1'b0);
      // Temperature flag on pad 8, then on disallowed pad 3
      temp <= 8'h4F;
      apb(1'b1, `GPA_TEMPMON_ADDR, 32'h00500801);
      tick(4);
      chk("temp_below", pad_out[7], 1'b0);
      temp <= 8'h50;
      tick(4);
      chk("temp_flag", {pad_oe[7], pad_out[7]}, 2'b11);
      apb(1'b1, `GPA_TEMPMON_ADDR, 32'h00500301);
      tick(4);
      chk("temp_bad_pad", pad_oe[2], 1'b0);
      // Flag on pad 5 takes over its monitor function
      apb(1'b1, `GPA_TEMPMON_ADDR, 32'h00500501);
      tick(4);
      chk("temp_on_pad5", {pad_oe[4], pad_out[4]}, 2'b11);
      conclude;
   end
endmodule
